//--- antc_pkg.sv
package antc_pkg;

   // Register map
   localparam logic [11:0] ANTC_TX_AUTONEG_CONFIG_OFS = 12'h178;
   localparam logic [31:0] ANTC_TX_AUTONEG_CONFIG_RST = 32'h0000_0000;

   // Register fields
   localparam int ANTC_HW_NEG_EN_BIT = 31;
   localparam int ANTC_FORCE_CFG_BIT = 30;
   localparam int ANTC_RSVD_HI = 29;
   localparam int ANTC_RSVD_LO = 16;
   localparam int ANTC_WORD_HI = 15;
   localparam int ANTC_WORD_LO = 0;

   // Advertised word fields
   localparam int ANTC_ADV_NEXT_PAGE_BIT = 15;
   localparam int ANTC_ADV_PAUSE_HI = 8;
   localparam int ANTC_ADV_PAUSE_LO = 7;
   localparam int ANTC_ADV_HALF_DUPLEX_BIT = 6;
   localparam int ANTC_ADV_FULL_DUPLEX_BIT = 5;

   // Reset values of the individual fields
   localparam logic [15:0] ANTC_ADV_WORD_RST = 16'h0000;
   localparam logic ANTC_FORCE_CFG_RST = 1'h0;
   localparam logic ANTC_HW_NEG_EN_RST = 1'h0;

   // Synchroniser depth for the receive sync status
   localparam int ANTC_SYNC_STAGES = 2;

   // Transmit source selection, one-hot
   typedef enum logic [2:0] {
      ANTC_TX_DATA  = 3'h1,
      ANTC_TX_SWCFG = 3'h2,
      ANTC_TX_HWNEG = 3'h4
   } antc_tx_sel_t;

endpackage

//--- antc_sync.sv
`timescale 1ns/1ps
module antc_sync
   import antc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Asynchronous level in, synchronised level out
   input wire logic async_i,
   output logic sync_o
);

   typedef struct packed {
      logic meta;
      logic stable;
   } antc_sync_state_t;

   antc_sync_state_t s_q;
   antc_sync_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.meta = async_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.stable;

endmodule

//--- antc_tx_config.sv
`timescale 1ns/1ps
// Overview of operation
// - Hardware mode sends word inside /C/ sets
// - Software mode sends written word, flag-gated
// - Readback equals last write or EEPROM load, stays stable
// - Word fields: next page, pause, duplex
// - EEPROM loads word bits 5, 7, 8
// - Bits 29:16 read zero, written zero
// - Force flag 1 sends /C/, 0 data, in ten-bit mode with enable clear
// - Enable bit runs hardware negotiation machine in ten-bit mode
// - Writing enable 1 pulses negotiation restart
// - Regained sync restarts negotiation when enabled
// - EEPROM loads hardware negotiation enable bit
module antc_tx_config
   import antc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // EEPROM defaults, one-cycle load strobe after chip reset
   input wire logic ee_load_i,
   input wire logic ee_full_duplex_i,
   input wire logic [1:0] ee_pause_i,
   input wire logic ee_hw_neg_en_i,
   // Link status and mode
   input wire logic ten_bit_interface_mode_i,
   input wire logic rx_sync_i,
   // Towards the ordered-set encoder and negotiation machine
   output logic [15:0] advertised_word_o,
   output logic force_config_sets_o,
   output logic hw_negotiation_enable_o,
   output logic hw_neg_run_o,
   output logic send_config_sets_o,
   output logic an_restart_o
);

   typedef struct packed {
      logic [15:0] adv;
      logic force_cfg;
      logic hw_en;
      logic ack;
      logic [31:0] rdat;
      logic restart;
      logic sync_prev;
      antc_tx_sel_t tx;
   } antc_state_t;

   antc_state_t s_q;
   antc_state_t s_d;
   logic rx_sync;
   logic req;
   logic hit;
   logic wr_fire;
   logic ane_wr1;
   logic sync_rise;

   function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic en);
      lane_merge = en ? new_v : old_v;
   endfunction

   antc_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(rx_sync_i),
      .sync_o(rx_sync)
   );

   assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
   assign hit = (wb_adr_i == ANTC_TX_AUTONEG_CONFIG_OFS);
   assign wr_fire = req & wb_we_i & hit;
   assign ane_wr1 = wr_fire & wb_sel_i[3] & wb_dat_i[ANTC_HW_NEG_EN_BIT];
   assign sync_rise = rx_sync & ~s_q.sync_prev;

   always_comb begin
      s_d = s_q;
      s_d.ack = req;
      s_d.sync_prev = rx_sync;
      // Write takes effect at the edge that raises ack
      if (wr_fire) begin
         s_d.adv[7:0] = lane_merge(s_q.adv[7:0], wb_dat_i[7:0], wb_sel_i[0]);
         s_d.adv[15:8] = lane_merge(s_q.adv[15:8], wb_dat_i[15:8], wb_sel_i[1]);
         if (wb_sel_i[3]) begin
            s_d.force_cfg = wb_dat_i[ANTC_FORCE_CFG_BIT];
            s_d.hw_en = wb_dat_i[ANTC_HW_NEG_EN_BIT];
         end
      end
      // EEPROM defaults override the same bits of a concurrent write
      if (ee_load_i) begin
         s_d.adv[ANTC_ADV_FULL_DUPLEX_BIT] = ee_full_duplex_i;
         s_d.adv[ANTC_ADV_PAUSE_HI:ANTC_ADV_PAUSE_LO] = ee_pause_i;
         s_d.hw_en = ee_hw_neg_en_i;
      end
      // Single-cycle restart on every write of 1 or on regained sync while enabled
      s_d.restart = ane_wr1 | (s_q.hw_en & sync_rise);
      s_d.rdat = '0;
      if (req & hit & ~wb_we_i) begin
         s_d.rdat[ANTC_WORD_HI:ANTC_WORD_LO] = s_q.adv;
         s_d.rdat[ANTC_FORCE_CFG_BIT] = s_q.force_cfg;
         s_d.rdat[ANTC_HW_NEG_EN_BIT] = s_q.hw_en;
      end
      case (s_q.tx)
         ANTC_TX_DATA, ANTC_TX_SWCFG, ANTC_TX_HWNEG: begin
            if (!ten_bit_interface_mode_i) begin
               s_d.tx = ANTC_TX_DATA;
            end else if (s_q.hw_en) begin
               s_d.tx = ANTC_TX_HWNEG;
            end else if (s_q.force_cfg) begin
               s_d.tx = ANTC_TX_SWCFG;
            end else begin
               s_d.tx = ANTC_TX_DATA;
            end
         end
         default: begin
            s_d.tx = ANTC_TX_DATA;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.adv <= ANTC_ADV_WORD_RST;
         s_q.force_cfg <= ANTC_FORCE_CFG_RST;
         s_q.hw_en <= ANTC_HW_NEG_EN_RST;
         s_q.ack <= 1'h0;
         s_q.rdat <= ANTC_TX_AUTONEG_CONFIG_RST;
         s_q.restart <= 1'h0;
         s_q.sync_prev <= 1'h0;
         s_q.tx <= ANTC_TX_DATA;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdat;
   assign advertised_word_o = s_q.adv;
   assign force_config_sets_o = s_q.force_cfg;
   assign hw_negotiation_enable_o = s_q.hw_en;
   assign hw_neg_run_o = (s_q.tx == ANTC_TX_HWNEG);
   assign send_config_sets_o = (s_q.tx == ANTC_TX_SWCFG);
   assign an_restart_o = s_q.restart;

   // Checks
   sequence ane_write_s;
      wr_fire && wb_sel_i[3] && wb_dat_i[ANTC_HW_NEG_EN_BIT] && !ee_load_i;
   endsequence

   sequence sync_regain_s;
      !rx_sync ##1 rx_sync && hw_negotiation_enable_o;
   endsequence

   wr_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ane_write_s |=> an_restart_o && hw_negotiation_enable_o)
      else $error("enable write of 1 gave no restart pulse");

   sync_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sync_regain_s |=> an_restart_o)
      else $error("regained sync gave no restart pulse");

   restart_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      an_restart_o |-> $past(ane_wr1) || ($past(s_q.hw_en) && $past(sync_rise)))
      else $error("restart pulse without a cause");

   restart_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
      an_restart_o |=> !an_restart_o || $past(ane_wr1) || $past(sync_rise))
      else $error("restart pulse longer than one cycle");

   rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[ANTC_RSVD_HI:ANTC_RSVD_LO] == 14'h0000)
      else $error("reserved bits read non-zero");

   readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fire && wb_sel_i[1:0] == 2'h3 && !ee_load_i ##1 (!wr_fire && !ee_load_i) [*2]
      |-> advertised_word_o == $past(wb_dat_i[15:0], 2))
      else $error("advertised word does not hold written value");

   ee_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ee_load_i |=> advertised_word_o[ANTC_ADV_FULL_DUPLEX_BIT] == $past(ee_full_duplex_i)
      && advertised_word_o[ANTC_ADV_PAUSE_HI:ANTC_ADV_PAUSE_LO] == $past(ee_pause_i))
      else $error("eeprom word bits not loaded");

   ee_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ee_load_i |=> hw_negotiation_enable_o == $past(ee_hw_neg_en_i))
      else $error("eeprom enable bit not loaded");

   sw_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ten_bit_interface_mode_i && !hw_negotiation_enable_o && force_config_sets_o
      |=> send_config_sets_o || $past(wr_fire) || $past(ee_load_i))
      else $error("force flag did not select config sets");

   sw_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !force_config_sets_o [*2] |-> !send_config_sets_o)
      else $error("config sets sent with force flag clear");

   hw_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      hw_neg_run_o |-> $past(hw_negotiation_enable_o) && !send_config_sets_o)
      else $error("hardware negotiation running while disabled");

   hw_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
      hw_neg_run_o |-> $past(ten_bit_interface_mode_i))
      else $error("hardware mode selected outside ten-bit mode");

   // Bus handshake
   ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o
      |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");

   ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o
      |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");

   rdat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o
      |-> wb_dat_o == 32'h0)
      else $error("read data driven outside an ack cycle");

   rd_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(!wb_we_i && hit)
      |-> wb_dat_o[15:0] == $past(advertised_word_o))
      else $error("read data differs from advertised word");

   rd_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(!wb_we_i && hit)
      |-> wb_dat_o[31] == $past(hw_negotiation_enable_o) && wb_dat_o[30] == $past(force_config_sets_o))
      else $error("read flags differ from register");

   unmapped_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(!hit)
      |-> wb_dat_o == 32'h0)
      else $error("unmapped read returned non-zero");

   rd_after_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(wb_we_i)
      |-> wb_dat_o == 32'h0)
      else $error("write cycle returned read data");

   // Register storage
   unmapped_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && wb_we_i && !hit && !ee_load_i
      |=> $stable(advertised_word_o) && $stable(force_config_sets_o) && $stable(hw_negotiation_enable_o))
      else $error("unmapped write changed the register");

   wr_lo_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fire && wb_sel_i[0] && !ee_load_i
      |=> advertised_word_o[7:0] == $past(wb_dat_i[7:0]))
      else $error("low byte write lost");

   wr_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fire && wb_sel_i[1] && !ee_load_i
      |=> advertised_word_o[15:8] == $past(wb_dat_i[15:8]))
      else $error("high byte write lost");

   keep_lo_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fire && !wb_sel_i[0] && !ee_load_i
      |=> $stable(advertised_word_o[7:0]))
      else $error("disabled low byte lane changed");

   keep_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fire && !wb_sel_i[1] && !ee_load_i
      |=> $stable(advertised_word_o[15:8]))
      else $error("disabled high byte lane changed");

   flag_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fire && !wb_sel_i[3] && !ee_load_i
      |=> $stable(force_config_sets_o) && $stable(hw_negotiation_enable_o))
      else $error("disabled flag lane changed");

   force_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fire && wb_sel_i[3]
      |=> force_config_sets_o == $past(wb_dat_i[ANTC_FORCE_CFG_BIT]))
      else $error("force flag write lost");

   hold_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !wr_fire && !ee_load_i
      |=> $stable(advertised_word_o) && $stable(force_config_sets_o) && $stable(hw_negotiation_enable_o))
      else $error("register changed without a write");

   ee_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ee_load_i && !wr_fire
      |=> $stable(advertised_word_o[15:9]) && $stable(advertised_word_o[6]) && $stable(advertised_word_o[4:0]))
      else $error("eeprom load touched other word bits");

   ee_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ee_load_i && !wr_fire
      |=> $stable(force_config_sets_o))
      else $error("eeprom load touched the force flag");

   // Restart pulse
   no_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ane_wr1 && !sync_rise
      |=> !an_restart_o)
      else $error("restart pulse without write or sync event");

   sync_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !hw_negotiation_enable_o && !ane_wr1
      |=> !an_restart_o)
      else $error("sync restart while hardware negotiation disabled");

   // Transmit source
   data_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ten_bit_interface_mode_i
      |=> !hw_neg_run_o && !send_config_sets_o)
      else $error("config sets selected outside ten-bit mode");

   hw_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ten_bit_interface_mode_i && hw_negotiation_enable_o
      |=> hw_neg_run_o)
      else $error("hardware negotiation not selected");

   one_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
      hw_neg_run_o
      |-> !send_config_sets_o)
      else $error("two transmit sources selected");

   sw_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
      send_config_sets_o
      |-> $past(force_config_sets_o) && !$past(hw_negotiation_enable_o) && $past(ten_bit_interface_mode_i))
      else $error("software config sets without their conditions");

   hw_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !hw_negotiation_enable_o
      |=> !hw_neg_run_o)
      else $error("hardware negotiation runs while disabled");

endmodule

//--- antc_link_partner.sv
`timescale 1ns/1ps
module antc_link_partner (
   // Clock and control
   input wire logic clk_i,
   input wire logic lose_i,
   // Receive sync status towards the device
   output logic rx_sync_o
);
   // Sync moves off the controller edges, as if from another clock domain
   always @(posedge clk_i) rx_sync_o <= #37 ~lose_i;
endmodule

//--- antc_tx_config_test.sv
`timescale 1ns/1ps
module antc_tx_config_test;
   import antc_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ee_ld = 0, ee_fd = 0, ee_en = 0, ten_bit_interface_mode = 0, lose = 0;
   logic [11:0] adr = 0;
   logic [31:0] wdat = 0, rdat, q, d;
   logic [1:0] ee_p = 0;
   logic [3:0] sel = 4'hf;
   logic [15:0] word;
   logic ack, rx_sync, fcs, hen, run, scs, restart, rs;
   int failures = 0, n_checks = 0, seed = 46, cnt;

   always #50 clk_i = ~clk_i;

   antc_tx_config dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ee_load_i(ee_ld), .ee_full_duplex_i(ee_fd), .ee_pause_i(ee_p), .ee_hw_neg_en_i(ee_en),
      .ten_bit_interface_mode_i(ten_bit_interface_mode), .rx_sync_i(rx_sync), .advertised_word_o(word),
      .force_config_sets_o(fcs), .hw_negotiation_enable_o(hen), .hw_neg_run_o(run),
      .send_config_sets_o(scs), .an_restart_o(restart));
   antc_link_partner link_u (.clk_i(clk_i), .lose_i(lose), .rx_sync_o(rx_sync));

   task stop_test;
      $display("checks=%0d mismatches=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One classic cycle; read data and restart pulse are taken at the ack edge
   task wb(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= v;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         stop_test;
      end
      r = rdat;
      rs = restart;
      cyc <= 0;
      stb <= 0;
      @(posedge clk_i);
   endtask

   initial begin
      #1_000_000;
      failures++;
      stop_test;
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      wb(0, 12'h178, 0, q);
      chk(q, 0);
      chk({11'h0, word, fcs, hen, run, scs, restart}, 0);
      $display("reset test done");
      for (int i = 0; i < 40; i++) begin
         d = $random(seed) & 32'hc000_bfe0;
         if (i < 4) d[31:30] = i[1:0];
         ten_bit_interface_mode <= 1'($random(seed));
         wb(1, 12'h178, d, q);
         chk({31'h0, rs}, {31'h0, d[31]});
         wb(0, 12'h178, 0, q);
         chk(q, d & 32'hc000_ffff);
         chk({14'h0, word, fcs, hen}, {14'h0, d[15:0], d[30], d[31]});
         chk({30'h0, run, scs}, {30'h0, ten_bit_interface_mode & d[31], ten_bit_interface_mode & ~d[31] & d[30]});
      end
      $display("register test done");
      for (int i = 0; i < 4; i++) begin
         ee_fd <= 1'($random(seed));
         ee_p <= 2'($random(seed));
         ee_en <= 1'($random(seed));
         ee_ld <= 1;
         @(posedge clk_i);
         ee_ld <= 0;
         @(posedge clk_i);
         d = {ee_en, d[30], 14'h0, d[15:9], ee_p, d[6], ee_fd, d[4:0]};
         wb(0, 12'h178, 0, q);
         chk(q, d);
      end
      sel <= 4'h1;
      wb(1, 12'h178, 32'hc000_aa55, q);
      chk({31'h0, rs}, 0);
      sel <= 4'hf;
      wb(0, 12'h178, 0, q);
      chk(q, {d[31:8], 8'h55});
      d = q;
      $display("eeprom test done");
      for (int k = 0; k < 2; k++) begin
         wb(1, 12'h178, {~k[0], 31'h0}, q);
         lose <= 1;
         repeat (4) @(posedge clk_i);
         lose <= 0;
         cnt = 0;
         repeat (8) begin
            @(posedge clk_i);
            cnt += int'(restart === 1'b1);
         end
         chk(32'(cnt), {31'h0, ~k[0]});
      end
      $display("sync test done");
      ten_bit_interface_mode <= 0;
      wb(1, 12'h178, 0, q);
      wb(1, 12'h17c, 32'hffff_ffff, q);
      wb(0, 12'h17c, 0, q);
      chk(q, 0);
      wb(0, 12'h178, 0, q);
      chk(q, 0);
      $display("copper test done");
      stop_test;
   end
endmodule
